// File: hdl/pesc_pkg.sv
// Package of register map, field layouts and types for the event status counters
package pesc_pkg;
   localparam logic [5:0]  PESC_OFF_FIRST  = 6'h12;
   localparam logic [5:0]  PESC_OFF_SECOND = 6'h13;
   localparam logic [5:0]  PESC_OFF_FCC    = 6'h14;
   localparam logic [5:0]  PESC_OFF_REC    = 6'h15;
   localparam logic [5:0]  PESC_OFF_CTRL   = 6'h16;
   localparam int          PESC_NUM_EV     = 8;
   localparam int          PESC_EN_LSB     = 0;
   localparam int          PESC_ST_LSB     = 8;
   localparam int          PESC_CTRL_POL   = 3;
   localparam int          PESC_CTRL_GIE   = 1;
   localparam logic [15:0] PESC_CTRL_RST   = 16'h0008;
   localparam logic [15:0] PESC_CTRL_MASK  = 16'h000a;
   localparam logic [7:0]  PESC_FCC_MAX    = 8'hff;
   localparam logic [15:0] PESC_REC_MAX    = 16'hffff;
   localparam logic [15:0] PESC_HALF       = 16'h007f;
   localparam int          PESC_HF_FC_BIT  = 9;
   localparam int          PESC_HF_RE_BIT  = 8;
   localparam int          PESC_FC_EN_BIT  = 1;
   localparam int          PESC_RE_EN_BIT  = 0;

   // Event inputs, one per status bit of the second bank
   typedef struct packed {
      logic eee_err;
      logic an_err;
      logic page_rx;
      logic lb_fifo;
      logic xover_chg;
      logic sleep_ev;
      logic pol_wol;
      logic jabber;
   } pesc_events_t;

   // Receive path qualifiers
   typedef struct packed {
      logic false_carrier;
      logic rx_dv;
      logic rx_invalid;
      logic loopback;
   } pesc_rx_t;
endpackage

// File: hdl/pesc_top.sv
// Event status bank, error counters and Wishbone slave
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module pesc_top
   import pesc_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   output logic              wb_err_o,
   input  wire pesc_events_t ev_i,
   input  wire pesc_rx_t     rx_i,
   output logic              int_out,
   output logic              int_req
);
   // ***************************************
   // Bus decode
   // ***************************************
   logic [5:0]  idx;
   logic        req;
   logic        hit_first;
   logic        hit_second;
   logic        hit_fcc;
   logic        hit_rec;
   logic        hit_ctrl;
   logic        mapped;
   logic        take;
   logic        wr;
   logic        rd;
   logic        wr_lo;
   logic        wr_hi;
   logic        ack_reg;
   logic        err_reg;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;

   assign idx        = wb_adr_i[7:2];
   assign req        = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
   assign hit_first  = (idx == PESC_OFF_FIRST);
   assign hit_second = (idx == PESC_OFF_SECOND);
   assign hit_fcc    = (idx == PESC_OFF_FCC);
   assign hit_rec    = (idx == PESC_OFF_REC);
   assign hit_ctrl   = (idx == PESC_OFF_CTRL);
   assign mapped     = hit_first | hit_second | hit_fcc | hit_rec | hit_ctrl;
   assign take       = req & mapped;
   assign wr         = take & wb_we_i;
   assign rd         = take & ~wb_we_i;
   assign wr_lo      = wr & wb_sel_i[0];
   assign wr_hi      = wr & wb_sel_i[1];

   // ***************************************
   // Status and enable registers
   // ***************************************
   logic [7:0]  st2_reg;
   logic [7:0]  st2_next;
   logic [7:0]  en2_reg;
   logic [1:0]  st1_reg;
   logic [1:0]  st1_next;
   logic [1:0]  en1_reg;
   logic [15:0] ctrl_reg;
   logic [7:0]  ev_vec;
   logic        fc_hf;
   logic        re_hf;

   assign ev_vec = ev_i;
   // Set wins over the read clear
   assign st2_next = ((rd & hit_second) ? 8'h00 : st2_reg) | ev_vec;
   assign st1_next = ((rd & hit_first) ? 2'h0 : st1_reg) | {fc_hf, re_hf};

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st2_reg <= 8'h00;
         st1_reg <= 2'h0;
      end else begin
         st2_reg <= st2_next;
         st1_reg <= st1_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         en2_reg  <= 8'h00;
         en1_reg  <= 2'h0;
         ctrl_reg <= PESC_CTRL_RST;
      end else begin
         if (wr_lo & hit_second) begin
            en2_reg <= wb_dat_i[7:0];
         end
         if (wr_lo & hit_first) begin
            en1_reg <= wb_dat_i[1:0];
         end
         if (wr_lo & hit_ctrl) begin
            ctrl_reg <= wb_dat_i[15:0] & PESC_CTRL_MASK;
         end
      end
   end

   // ***************************************
   // Error counters
   // ***************************************
   logic [7:0]  fcc_reg;
   logic [7:0]  fcc_next;
   logic [15:0] rec_reg;
   logic [15:0] rec_next;
   logic        fc_inc;
   logic        re_inc;

   assign fc_inc = rx_i.false_carrier & (fcc_reg != PESC_FCC_MAX);
   assign re_inc = rx_i.rx_dv & rx_i.rx_invalid & ~rx_i.loopback
                 & (rec_reg != PESC_REC_MAX);
   assign fcc_next = (rd & hit_fcc) ? 8'h00 : fcc_reg + 8'(fc_inc);
   assign rec_next = (rd & hit_rec) ? 16'h0000 : rec_reg + 16'(re_inc);
   // Event on the crossing above PESC_HALF, from 127 to 128, for both counters
   assign fc_hf = fc_inc & ({8'h00, fcc_reg} == PESC_HALF);
   assign re_hf = re_inc & (rec_reg == PESC_HALF);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fcc_reg <= 8'h00;
         rec_reg <= 16'h0000;
      end else begin
         fcc_reg <= fcc_next;
         rec_reg <= rec_next;
      end
   end

   // ***************************************
   // Interrupt output
   // ***************************************
   logic pend;
   logic int_next;
   logic irq_reg;

   assign pend = |(st2_reg & en2_reg) | |(st1_reg & en1_reg);
   assign int_next = pend & ctrl_reg[PESC_CTRL_GIE];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= int_next;
      end
   end

   assign int_req = irq_reg;
   assign int_out = irq_reg ^ ctrl_reg[PESC_CTRL_POL];

   // ***************************************
   // Read data and acknowledge
   // ***************************************
   always_comb begin
      dat_next = 32'h0000_0000;
      if (hit_second) begin
         dat_next[15:0] = {st2_reg, en2_reg};
      end else if (hit_first) begin
         dat_next[15:0] = {6'h00, st1_reg, 6'h00, en1_reg};
      end else if (hit_fcc) begin
         dat_next[15:0] = {8'h00, fcc_reg};
      end else if (hit_rec) begin
         dat_next[15:0] = rec_reg;
      end else if (hit_ctrl) begin
         dat_next[15:0] = ctrl_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= take;
         err_reg <= req & ~mapped;
         if (rd) begin
            dat_reg <= dat_next;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign wb_dat_o = dat_reg;
endmodule

// File: test/pesc_chk_asserts.sv
// Bus and interrupt pin checks for the status counters
`timescale 1ns/1ps
module pesc_chk (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic        int_out,
   input wire logic        int_req
);
   // ****
   // Assertions
   // ****
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire mapped = wb_adr_i[7:2] >= 6'h12 && wb_adr_i[7:2] <= 6'h16;
   a_ack_mapped: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
      else $error("mapped request not acknowledged");
   a_err_unmapped: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
      else $error("unmapped request not refused");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_err_pulse: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_fall_after_access: assert property ($fell(int_req) |-> $past(wb_ack_o))
      else $error("request dropped without access");
   a_out_follows_req: assert property
      ($changed(int_req) && !wb_ack_o && !$past(wb_ack_o) |-> $changed(int_out))
      else $error("pin did not follow request");
endmodule
bind pesc_top pesc_chk i_chk (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .int_out(int_out), .int_req(int_req));

// File: test/pesc_host.sv
// Management host model issuing Wishbone register cycles
`timescale 1ns/1ps
module pesc_host (
   input  wire logic        mclk,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [7:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      dat,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack,
   input  wire logic        err
);
   // ****
   // Single classic cycle
   // ****
   initial {cyc, stb, we, adr, sel, dat} = '0;
   task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge mclk);
      {cyc, stb, we, sel} <= {2'b11, w, 4'hf};
      adr <= a;
      dat <= {16'h0000, d};
      do @(posedge mclk); while (!(ack || err));
      q = dat_o;
      e = err;
      {cyc, stb} <= 2'b00;
      adr <= ~a;
      dat <= ~dat;
   endtask
endmodule

// File: test/phy_event_status_counters_bench.sv
// Self-checking bench for the event status counters
`timescale 1ns/1ps
module phy_event_status_counters_bench
   import pesc_pkg::*;
;
   logic         mclk, sys_rst, cyc, stb, we, ack, err, int_out, int_req, e;
   logic [7:0]   adr;
   logic [3:0]   sel;
   logic [31:0]  dat, dat_o, q;
   pesc_events_t ev;
   pesc_rx_t     rx;
   int           mismatches = 0, comparisons = 0, cycles = 0;
   pesc_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .ev_i(ev), .rx_i(rx), .int_out(int_out),
      .int_req(int_req));
   pesc_host i_host (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
      .dat(dat), .dat_o(dat_o), .ack(ack), .err(err));
   // ****
   // Tasks and tests
   // ****
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] x);
      i_host.xfer(a, 1'b0, 16'h0000, q, e);
      chk(q, {16'h0000, x});
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      i_host.xfer(a, 1'b1, d, q, e);
   endtask
   task automatic hold(input pesc_rx_t v, input int n);
      rx <= v;
      repeat (n) @(posedge mclk);
      rx <= '0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic pulse(input pesc_events_t v);
      ev <= v;
      @(posedge mclk);
      ev <= '0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      sys_rst = 1'b1;
      ev = '0;
      rx = '0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(8'h4c, 16'h0000);
      rd(8'h50, 16'h0000);
      wr(8'h4c, 16'hffff);
      rd(8'h4c, 16'h00ff);
      wr(8'h48, 16'hffff);
      rd(8'h48, 16'h0003);
      i_host.xfer(8'hfc, 1'b0, 16'h0000, q, e);
      chk({31'h0, e}, 32'h1);
      $display("test registers done");
      wr(8'h58, 16'h000a);
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i);
         chk({30'h0, int_req, int_out}, 32'h2);
         rd(8'h4c, 16'h00ff | (16'h0100 << i));
         rd(8'h4c, 16'h00ff);
      end
      $display("test events done");
      wr(8'h58, 16'h0000);
      pulse(8'h01);
      chk({30'h0, int_req, int_out}, 32'h0);
      rd(8'h4c, 16'h01ff);
      $display("test gating done");
      hold(4'h8, 300);
      rd(8'h50, 16'h00ff);
      rd(8'h50, 16'h0000);
      rd(8'h48, 16'h0203);
      hold(4'h7, 20);
      hold(4'h2, 20);
      hold(4'h6, 300);
      rd(8'h54, 16'h012c);
      rd(8'h54, 16'h0000);
      rd(8'h48, 16'h0103);
      $display("test counters done");
      conclude();
   end
endmodule
